// ---- hdl/tio_core.sv ----
// tio_core: table lookup/interpolate, frame allocate/release, sync no-op, left shift
// assumes decoder holds req_i with start_i; bus unit answers mem_ack_i on same clock
// How it works
// - low index byte is fraction over 256
// - entry from bits 15:8, fraction 7:0
// - signed rounded result rounds nearest-even
// - signed/unsigned, rounded/unrounded, byte/word/long variants
// - register form: two endpoints, fraction from destination
// - left shift fills vacated low bits zero
// - frame allocate: push, link register, reserve area
// - frame release: sp from register, then pop
// - no-op waits for older instructions complete
`timescale 1ns/100ps
module tio_core import tio_pkg::*; (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic start_i,
  input wire tio_req_t req_i,
  input wire logic pipe_idle_i,
  output logic busy_o,
  output logic done_o,
  output tio_res_t res_o,
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [DW-1:0] mem_addr_o,
  output logic [DW-1:0] mem_wdata_o,
  output tio_size_t mem_size_o,
  input wire logic mem_ack_i,
  input wire logic [DW-1:0] mem_rdata_i
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_FETCH0 = 3'b001,
    ST_FETCH1 = 3'b010,
    ST_CALC = 3'b011,
    ST_PUSH = 3'b100,
    ST_POP = 3'b101,
    ST_SYNC = 3'b110,
    ST_DONE = 3'b111
  } tio_state_t;

  tio_state_t state_reg, state_next;
  tio_req_t req_reg;
  tio_res_t res_reg, res_next;
  logic [DW-1:0] e0_reg, e1_reg, addr_reg;
  logic [DW-1:0] e0_next, e1_next, addr_next;

  function automatic logic signed [DW:0] ext(input logic [DW-1:0] v, input tio_size_t s,
                                            input logic sg);
    logic signed [DW:0] r;
    r = '0;
    case (s)
      TIO_SZ_BYTE: r = {{(DW-7){sg & v[7]}}, v[7:0]};
      TIO_SZ_WORD: r = {{(DW-15){sg & v[15]}}, v[15:0]};
      default: r = {sg & v[DW-1], v};
    endcase
    return r;
  endfunction : ext

  // operand selection
  wire [FRAC_W-1:0] frac = req_reg.index_data_register[FRAC_LO +: FRAC_W];
  wire [ENTRY_W-1:0] entry = req_reg.index_data_register[ENTRY_LO +: ENTRY_W];
  wire [DW-1:0] step = (req_reg.size == TIO_SZ_BYTE) ? 32'h0000_0001 :
                       (req_reg.size == TIO_SZ_WORD) ? 32'h0000_0002 : LONG_BYTES;
  wire [DW-1:0] entry_off = {24'h00_0000, entry} * step;
  wire [DW-1:0] first_addr = req_reg.eff_addr + entry_off;

  // interpolation arithmetic
  wire signed [DW:0] x0 = ext(e0_reg, req_reg.size, req_reg.is_signed);
  wire signed [DW:0] x1 = ext(e1_reg, req_reg.size, req_reg.is_signed);
  wire signed [DW+1:0] diff = {x1[DW], x1} - {x0[DW], x0};
  wire signed [DW+10:0] prod = diff * $signed({1'b0, frac});
  wire signed [DW+10:0] full = ({{10{x0[DW]}}, x0} <<< FRAC_W) + prod;
  wire [FRAC_W-1:0] rem = full[FRAC_W-1:0];
  wire rnd_up = (rem > HALF_LSB) || ((rem == HALF_LSB) && full[FRAC_W]);
  wire [DW-1:0] whole = full[FRAC_W +: DW];
  wire [DW-1:0] rounded = whole + {31'h0000_0000, rnd_up};
  wire [DW-1:0] tbl_out = req_reg.round ? rounded : full[DW-1:0];
  wire [DW-1:0] shl_out = req_reg.index_data_register << req_reg.shift_cnt;
  wire [DW-1:0] push_addr = req_reg.stack_ptr - LONG_BYTES;

  always_comb begin
    state_next = state_reg;
    res_next = res_reg;
    e0_next = e0_reg;
    e1_next = e1_reg;
    addr_next = addr_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start_i) begin
          res_next = '0;
          case (req_i.op)
            TIO_OP_TBL_MEM: state_next = ST_FETCH0;
            TIO_OP_TBL_REG: state_next = ST_CALC;
            TIO_OP_LINK: state_next = ST_PUSH;
            TIO_OP_UNLINK: state_next = ST_POP;
            TIO_OP_NOP: state_next = ST_SYNC;
            default: state_next = ST_CALC;
          endcase
        end
      end
      ST_FETCH0: begin
        addr_next = first_addr;
        if (mem_ack_i) begin
          e0_next = mem_rdata_i;
          addr_next = first_addr + step;
          state_next = ST_FETCH1;
        end
      end
      ST_FETCH1: begin
        if (mem_ack_i) begin
          e1_next = mem_rdata_i;
          state_next = ST_CALC;
        end
      end
      ST_CALC: begin
        res_next.dest_we = 1'b1;
        res_next.dest = (req_reg.op == TIO_OP_SHL) ? shl_out : tbl_out;
        state_next = ST_DONE;
      end
      ST_PUSH: begin
        if (mem_ack_i) begin
          res_next.an_we = 1'b1;
          res_next.an = push_addr;
          res_next.sp_we = 1'b1;
          res_next.sp = push_addr + req_reg.disp;
          state_next = ST_DONE;
        end
      end
      ST_POP: begin
        if (mem_ack_i) begin
          res_next.an_we = 1'b1;
          res_next.an = mem_rdata_i;
          res_next.sp_we = 1'b1;
          res_next.sp = req_reg.addr_reg_val + LONG_BYTES;
          state_next = ST_DONE;
        end
      end
      ST_SYNC: begin
        if (pipe_idle_i) begin
          state_next = ST_DONE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // register form loads endpoints directly
  wire load_reg_form = (state_reg == ST_IDLE) && start_i && (req_i.op == TIO_OP_TBL_REG);

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state_reg <= ST_IDLE;
      req_reg <= '0;
      res_reg <= '0;
      e0_reg <= ZERO_WORD;
      e1_reg <= ZERO_WORD;
      addr_reg <= ZERO_WORD;
    end else if (ce_i) begin
      state_reg <= state_next;
      res_reg <= res_next;
      addr_reg <= addr_next;
      if ((state_reg == ST_IDLE) && start_i) begin
        req_reg <= req_i;
      end
      e0_reg <= load_reg_form ? req_i.first_endpoint : e0_next;
      e1_reg <= load_reg_form ? req_i.second_endpoint_register : e1_next;
    end
  end

  // bus requests
  wire rd_fetch = (state_reg == ST_FETCH0) || (state_reg == ST_FETCH1);
  assign mem_req_o = rd_fetch || (state_reg == ST_PUSH) || (state_reg == ST_POP);
  assign mem_we_o = (state_reg == ST_PUSH);
  assign mem_addr_o = (state_reg == ST_FETCH0) ? first_addr :
                      (state_reg == ST_FETCH1) ? addr_reg :
                      (state_reg == ST_PUSH) ? push_addr : req_reg.addr_reg_val;
  assign mem_wdata_o = req_reg.addr_reg_val;
  assign mem_size_o = rd_fetch ? req_reg.size : TIO_SZ_LONG;
  assign busy_o = (state_reg != ST_IDLE);
  assign done_o = (state_reg == ST_DONE);
  assign res_o = res_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i || !ce_i);

  wire is_tbl = (req_reg.op == TIO_OP_TBL_MEM) || (req_reg.op == TIO_OP_TBL_REG);
  wire signed [DW+10:0] res_scaled = {{11{res_o.dest[DW-1]}}, res_o.dest} <<< FRAC_W;
  wire signed [DW+10:0] round_err = full - res_scaled;

  second_entry_a: assert property (mem_req_o && (state_reg == ST_FETCH1) |->
    mem_addr_o == $past(first_addr) + step) else $error("second entry address wrong");
  entry_field_a: assert property ($rose(state_reg == ST_FETCH0) |->
    mem_addr_o == req_reg.eff_addr + {24'h00_0000, req_reg.index_data_register[15:8]} * step)
    else $error("entry field not bits 15:8");
  interp_raw_a: assert property (done_o && is_tbl && !req_reg.round |->
    res_o.dest == 32'(($signed(x0) * 256) + $signed(diff) * $signed({1'b0, frac})))
    else $error("unrounded interpolation wrong");
  round_even_a: assert property (done_o && is_tbl && req_reg.round && req_reg.is_signed |->
    (round_err <= 128) && (round_err >= -128) && (round_err != 128 || !res_o.dest[0]))
    else $error("rounding not nearest even");
  unsigned_byte_a: assert property (done_o && is_tbl && req_reg.round && !req_reg.is_signed &&
    (req_reg.size == TIO_SZ_BYTE) |-> res_o.dest[DW-1:FRAC_W] == 24'h00_0000)
    else $error("unsigned byte result out of range");
  surface_ops_a: assert property (state_reg == ST_IDLE && start_i &&
    req_i.op == TIO_OP_TBL_REG |=> e0_reg == $past(req_i.first_endpoint) &&
    e1_reg == $past(req_i.second_endpoint_register) && !mem_req_o)
    else $error("surface endpoints not loaded");
  shift_zero_a: assert property (done_o && req_reg.op == TIO_OP_SHL |->
    (res_o.dest & ~(32'hFFFF_FFFF << req_reg.shift_cnt)) == ZERO_WORD)
    else $error("shift left did not zero fill");
  frame_alloc_a: assert property (done_o && req_reg.op == TIO_OP_LINK |->
    res_o.an == req_reg.stack_ptr - 4 && res_o.sp == res_o.an + req_reg.disp)
    else $error("frame allocate wrong");
  frame_release_a: assert property (state_reg == ST_POP && mem_ack_i |=>
    done_o && res_o.an == $past(mem_rdata_i) && res_o.sp == req_reg.addr_reg_val + 4)
    else $error("frame release wrong");
  nop_sync_a: assert property (state_reg == ST_SYNC && !pipe_idle_i |=>
    state_reg == ST_SYNC && !done_o) else $error("no-op ran before pipeline idle");

  mem_lookup_c: cover property (done_o && req_reg.op == TIO_OP_TBL_MEM && req_reg.round);
  surface_c: cover property (done_o && req_reg.op == TIO_OP_TBL_REG && req_reg.is_signed);
  link_unlink_c: cover property (done_o && req_reg.op == TIO_OP_LINK ##[1:20]
    done_o && req_reg.op == TIO_OP_UNLINK);
  nop_wait_c: cover property (state_reg == ST_SYNC && !pipe_idle_i ##[1:20] done_o);
endmodule : tio_core

// ---- include/tio_pkg.sv ----
// tio_pkg: shared types and constants for the table interpolate and frame datapath
// assumes one core clock; operands come from the register file, memory via core bus unit
package tio_pkg;
  localparam int unsigned DW = 32;
  localparam int unsigned FRAC_W = 8;
  localparam int unsigned FRAC_LO = 0;
  localparam int unsigned ENTRY_LO = 8;
  localparam int unsigned ENTRY_W = 8;
  localparam logic [DW-1:0] LONG_BYTES = 32'h0000_0004;
  localparam logic [FRAC_W-1:0] HALF_LSB = 8'h80;
  localparam logic [DW-1:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [4:0] ZERO_CNT = 5'h00;

  typedef enum logic [2:0] {
    TIO_OP_TBL_MEM = 3'b000,
    TIO_OP_TBL_REG = 3'b001,
    TIO_OP_LINK    = 3'b010,
    TIO_OP_UNLINK  = 3'b011,
    TIO_OP_NOP     = 3'b100,
    TIO_OP_SHL     = 3'b101
  } tio_op_t;

  typedef enum logic [1:0] {
    TIO_SZ_BYTE = 2'b00,
    TIO_SZ_WORD = 2'b01,
    TIO_SZ_LONG = 2'b10
  } tio_size_t;

  typedef struct packed {
    tio_op_t op;
    tio_size_t size;
    logic is_signed;
    logic round;
    logic [4:0] shift_cnt;
    logic [DW-1:0] index_data_register;
    logic [DW-1:0] first_endpoint;
    logic [DW-1:0] second_endpoint_register;
    logic [DW-1:0] eff_addr;
    logic [DW-1:0] addr_reg_val;
    logic [DW-1:0] stack_ptr;
    logic [DW-1:0] disp;
  } tio_req_t;

  typedef struct packed {
    logic dest_we;
    logic [DW-1:0] dest;
    logic an_we;
    logic [DW-1:0] an;
    logic sp_we;
    logic [DW-1:0] sp;
  } tio_res_t;
endpackage : tio_pkg

// ---- bench/tb.sv ----
// tb: self-checking bench for tio_core
// assumes tio_pkg compiled first; bench plays decoder, pipeline and bus unit
`timescale 1ns/100ps
module tb;
  import tio_pkg::*;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic start_i = 1'b0;
  logic ce_i = 1'b1;
  logic pipe_idle_i = 1'b1;
  logic mem_ack_i = 1'b0;
  logic [DW-1:0] mem_rdata_i = 32'h0000_0000;
  tio_req_t req_i = '0;
  logic busy_o, done_o, mem_req_o, mem_we_o;
  logic [DW-1:0] mem_addr_o, mem_wdata_o;
  tio_res_t res_o;
  tio_size_t mem_size_o, sz_exp;
  int fail_count = 0;
  int total_checks = 0;
  logic [DW-1:0] a_q[$], d_q[$], wd_exp;
  logic we_exp;
  tio_core tio_core_inst (.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i),
    .start_i(start_i), .req_i(req_i), .pipe_idle_i(pipe_idle_i), .busy_o(busy_o),
    .done_o(done_o), .res_o(res_o), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o),
    .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_size_o(mem_size_o),
    .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i));
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic check(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic summarize();
    if (fail_count == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize
  function automatic int rne(input int v);
    int q;
    q = v >>> 8;
    if ((v & 255) > 128 || ((v & 255) == 128 && q[0])) q++;
    return q;
  endfunction : rne
  // one operation; bench answers bus requests at once
  task automatic run(input tio_req_t r, input int idle_at, output tio_res_t res,
                     output int cyc);
    @(negedge clk_i);
    req_i = r;
    start_i = 1'b1;
    pipe_idle_i = (idle_at == 0);
    @(negedge clk_i);
    start_i = 1'b0;
    for (cyc = 0; done_o !== 1'b1; cyc++) begin
      if (cyc > 40) begin
        fail_count++;
        summarize();
      end
      if (cyc == 0) check(busy_o, 1'b1);
      pipe_idle_i = (cyc >= idle_at);
      mem_ack_i = (mem_req_o === 1'b1);
      if (mem_ack_i) begin
        check(mem_addr_o, a_q.pop_front());
        mem_rdata_i = d_q.pop_front();
        check(mem_we_o, we_exp);
        check(mem_size_o, sz_exp);
        if (we_exp) check(mem_wdata_o, wd_exp);
      end else begin
        mem_rdata_i = ~mem_rdata_i;
      end
      @(negedge clk_i);
    end
    mem_ack_i = 1'b0;
    res = res_o;
    check(a_q.size(), 0);
  endtask : run
  task automatic t_reg();
    int e0[7] = '{1669, 1669, 80, 80, 0, 1, -2};
    int e1[7] = '{1679, 1679, 64, 64, 1, 2, -1};
    int ix[7] = '{'h1234A380, 'hA380, 'h0BD0, 'h0BD0, 'h80, 'h80, 'h80};
    bit sg[7] = '{0, 0, 1, 1, 1, 0, 1};
    bit rd[7] = '{0, 1, 0, 1, 1, 1, 1};
    tio_req_t r;
    tio_res_t res;
    int cyc, v;
    for (int k = 0; k < 7; k++) begin
      r = '0;
      r.op = TIO_OP_TBL_REG;
      r.size = TIO_SZ_LONG;
      r.is_signed = sg[k];
      r.round = rd[k];
      r.first_endpoint = e0[k];
      r.second_endpoint_register = e1[k];
      r.index_data_register = ix[k];
      v = e0[k] * 256 + (ix[k] & 255) * (e1[k] - e0[k]);
      run(r, 0, res, cyc);
      check(cyc, 1);
      check(res.dest_we, 1'b1);
      check(res.dest, rd[k] ? rne(v) : v);
    end
  endtask : t_reg
  task automatic t_mem(input tio_size_t sz, input bit sg, input bit rd, input int ea,
                       input int ix, input int d0, input int d1, input int exp);
    tio_req_t r;
    tio_res_t res;
    int cyc, st;
    st = (sz == TIO_SZ_LONG) ? 4 : (sz == TIO_SZ_WORD) ? 2 : 1;
    r = '0;
    r.op = TIO_OP_TBL_MEM;
    r.size = sz;
    r.is_signed = sg;
    r.round = rd;
    r.eff_addr = ea;
    r.index_data_register = ix;
    a_q = '{ea + ((ix >> 8) & 255) * st, ea + (((ix >> 8) & 255) + 1) * st};
    d_q = '{d0, d1};
    we_exp = 1'b0;
    sz_exp = sz;
    run(r, 0, res, cyc);
    check(cyc, 3);
    check(res.dest, exp);
  endtask : t_mem
  task automatic t_frame();
    tio_req_t r;
    tio_res_t res;
    int cyc;
    r = '0;
    r.op = TIO_OP_LINK;
    r.stack_ptr = 32'h0000_1000;
    r.addr_reg_val = 32'h1234_5678;
    r.disp = 32'hFFFF_FFF8;
    a_q = '{32'h0000_0FFC};
    d_q = '{32'h0000_0000};
    we_exp = 1'b1;
    wd_exp = 32'h1234_5678;
    sz_exp = TIO_SZ_LONG;
    run(r, 0, res, cyc);
    check(cyc, 1);
    check({res.an_we, res.sp_we}, 2'b11);
    check(res.an, 32'h0000_0FFC);
    check(res.sp, 32'h0000_0FF4);
    r.op = TIO_OP_UNLINK;
    r.addr_reg_val = 32'h0000_0FFC;
    d_q = '{32'h1234_5678};
    a_q = '{32'h0000_0FFC};
    we_exp = 1'b0;
    run(r, 0, res, cyc);
    check(cyc, 1);
    check(res.an, 32'h1234_5678);
    check(res.sp, 32'h0000_1000);
  endtask : t_frame
  task automatic t_nop_shl();
    tio_req_t r;
    tio_res_t res;
    int cyc;
    r = '0;
    r.op = TIO_OP_NOP;
    run(r, 5, res, cyc);
    check(cyc, 6);
    check({res.dest_we, res.an_we, res.sp_we}, 3'b000);
    r.op = TIO_OP_SHL;
    r.shift_cnt = 5'h04;
    r.index_data_register = 32'h0000_00BD;
    run(r, 0, res, cyc);
    check(cyc, 1);
    check(res.dest, 32'h0000_0BD0);
  endtask : t_nop_shl
  task automatic t_freeze();
    @(negedge clk_i);
    ce_i = 1'b0;
    req_i.op = TIO_OP_TBL_REG;
    start_i = 1'b1;
    repeat (3) @(negedge clk_i);
    check({busy_o, done_o}, 2'b00);
    start_i = 1'b0;
    ce_i = 1'b1;
  endtask : t_freeze
  initial begin
    repeat (16) @(negedge clk_i);
    check({busy_o, done_o, mem_req_o}, 3'b000);
    check(res_o.dest | res_o.an | res_o.sp, 32'h0000_0000);
    reset_n_i = 1'b1;
    t_reg();
    t_mem(TIO_SZ_WORD, 1'b0, 1'b1, 'h400, 'h5A5A028E, 1311, 1966, 1674);
    t_mem(TIO_SZ_BYTE, 1'b1, 1'b0, 'h100, 'h0310, 'hABCDEF80, 'h12345610, -30464);
    t_mem(TIO_SZ_BYTE, 1'b0, 1'b1, 'h200, 'h0BD0, 'hFFFFFF50, 'h00000040, 67);
    t_frame();
    t_freeze();
    t_nop_shl();
    summarize();
  end
endmodule : tb
